// [dv/cpe_engine_assertions.sv]
// port checker of the current and power engine
`timescale 1ns/1ps
module cpe_engine_assertions #(
   parameter int AVG_LOG2_MAX = 10,
   parameter int ACC_W = 27
) (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic [2:0] REG_ADDR,
   input wire logic [15:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [15:0] REG_RDATA,
   input wire logic [15:0] SHUNT_CODE,
   input wire logic SHUNT_VALID,
   input wire logic [15:0] SUPPLY_SENSE_CODE,
   input wire logic SUPPLY_SENSE_VALID,
   input wire logic [2:0] SHUNT_TIME_SEL,
   input wire logic [2:0] SUPPLY_TIME_SEL,
   input wire logic [2:0] AVG_COUNT_SEL,
   input wire logic RESULT_READY
);
   logic cal_zero_r;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   // tracks whether the scale is still zero
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST)
         cal_zero_r <= 1'h1;
      else if (REG_WR && REG_ADDR == 3'h5)
         cal_zero_r <= (REG_WDATA == 16'h0000);
   end
   // scale write, one idle cycle, then its read
   sequence s_wr_scale;
      REG_WR && REG_ADDR == 3'h5;
   endsequence
   sequence s_rd_scale;
      REG_RD && !REG_WR && REG_ADDR == 3'h5;
   endsequence
   AST_SEL: assert property (
      REG_WR && REG_ADDR == 3'h0 |=> {AVG_COUNT_SEL, SUPPLY_TIME_SEL,
      SHUNT_TIME_SEL} == $past(REG_WDATA[11:3]))
      else $error("select outputs differ from setup fields");
   AST_READY_ONE: assert property (
      RESULT_READY |=> !RESULT_READY)
      else $error("ready pulse longer than one cycle");
   AST_READY_LAT: assert property (
      RESULT_READY |-> $past(SUPPLY_SENSE_VALID, 34))
      else $error("ready not 34 cycles after a bus sample");
   AST_UNCAL: assert property (
      REG_RD && !REG_WR && cal_zero_r && (REG_ADDR == 3'h3 ||
      REG_ADDR == 3'h4) |=> REG_RDATA == 16'h0000)
      else $error("result nonzero while uncalibrated");
   AST_BUS_MSB: assert property (
      REG_RD && REG_ADDR == 3'h2 |=> !REG_RDATA[15])
      else $error("bus voltage top bit set");
   AST_HOLD: assert property (
      !REG_RD |=> $stable(REG_RDATA))
      else $error("read data moved without a read");
   AST_UNMAPPED: assert property (
      REG_RD && REG_ADDR > 3'h5 |=> REG_RDATA == 16'h0000)
      else $error("unmapped read not zero");
   AST_SCALE_BACK: assert property (
      s_wr_scale ##2 s_rd_scale |=> REG_RDATA == $past(REG_WDATA, 3))
      else $error("scale readback differs");
endmodule : cpe_engine_assertions
bind cpe_engine cpe_engine_assertions #(.AVG_LOG2_MAX(AVG_LOG2_MAX),
   .ACC_W(ACC_W)) i_cpe_engine_assertions (.SYS_CLK, .RST, .REG_ADDR,
   .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .SHUNT_CODE, .SHUNT_VALID,
   .SUPPLY_SENSE_CODE, .SUPPLY_SENSE_VALID, .SHUNT_TIME_SEL,
   .SUPPLY_TIME_SEL, .AVG_COUNT_SEL, .RESULT_READY);

// [dv/tb_cpe_engine.sv]
// self-checking bench of the current and power engine
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin err_total++; \
   $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb_cpe_engine;
   logic SYS_CLK, RST, REG_WR, REG_RD, SHUNT_VALID, SUPPLY_SENSE_VALID;
   logic RESULT_READY, rdy;
   logic [2:0] REG_ADDR, SHUNT_TIME_SEL, SUPPLY_TIME_SEL, AVG_COUNT_SEL;
   logic [15:0] REG_WDATA, REG_RDATA, SHUNT_CODE, SUPPLY_SENSE_CODE;
   int err_total = 0;
   int checked = 0;
   logic [8:0] sel_all;
   // setup select outputs seen as one word
   assign sel_all = {AVG_COUNT_SEL, SUPPLY_TIME_SEL, SHUNT_TIME_SEL};
   cpe_engine i_cpe_engine (.SYS_CLK, .RST, .REG_ADDR, .REG_WDATA, .REG_WR,
      .REG_RD, .REG_RDATA, .SHUNT_CODE, .SHUNT_VALID, .SUPPLY_SENSE_CODE,
      .SUPPLY_SENSE_VALID, .SHUNT_TIME_SEL, .SUPPLY_TIME_SEL,
      .AVG_COUNT_SEL, .RESULT_READY);
   // clock toggles each half period
   always #2.5 SYS_CLK = ~SYS_CLK;
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      REG_ADDR = a;
      REG_WDATA = d;
      REG_WR = 1'h1;
      @(negedge SYS_CLK);
      REG_WR = 1'h0;
      @(negedge SYS_CLK); // idle cycle before the next strobe
   endtask : wr
   task automatic rd(input logic [2:0] a, input logic [15:0] e);
      REG_ADDR = a;
      REG_RD = 1'h1;
      @(negedge SYS_CLK);
      REG_RD = 1'h0;
      `CHK($sformatf("reg %0d", a), e, REG_RDATA)
      @(negedge SYS_CLK); // idle cycle before the next strobe
   endtask : rd
   // shunt then bus sample, then watch for the window end
   task automatic smp(input logic [15:0] sh, input logic [15:0] bu);
      SHUNT_CODE = sh;
      SHUNT_VALID = 1'h1;
      @(negedge SYS_CLK);
      SHUNT_VALID = 1'h0;
      SUPPLY_SENSE_CODE = bu;
      SUPPLY_SENSE_VALID = 1'h1;
      @(negedge SYS_CLK);
      SUPPLY_SENSE_VALID = 1'h0;
      rdy = 1'h0;
      repeat (40) begin
         @(negedge SYS_CLK);
         rdy = rdy | RESULT_READY;
      end
   endtask : smp
   task automatic t_uncal;
      rd(3'h0, 16'h4127);
      rd(3'h5, 16'h0000);
      smp(16'h1F40, 16'h2570);
      `CHK("ready", 1'h1, rdy)
      rd(3'h4, 16'h0000);
      rd(3'h3, 16'h0000);
   endtask : t_uncal
   task automatic t_walk;
      wr(3'h0, 16'h415F);
      `CHK("sel", 9'h02B, sel_all)
      wr(3'h5, 16'h0A00);
      rd(3'h5, 16'h0A00);
      smp(16'h1F40, 16'h2570);
      rd(3'h4, 16'h2710);
      rd(3'h3, 16'h12B8);
      rd(3'h1, 16'h1F40);
      rd(3'h2, 16'h2570);
      smp(16'hFFFD, 16'hCE20);
      rd(3'h4, 16'hFFFD);
      rd(3'h3, 16'h0003);
      rd(3'h2, 16'h4E20);
   endtask : t_walk
   // four samples whose per-sample currents average lower than the shunt
   task automatic t_avg;
      wr(3'h5, 16'h0001);
      wr(3'h0, 16'h435F);
      smp(16'h07FF, 16'h4E20);
      `CHK("early ready", 1'h0, rdy)
      smp(16'h07FF, 16'h4E20);
      smp(16'h0801, 16'h4E20);
      smp(16'h0801, 16'h4E20);
      `CHK("ready", 1'h1, rdy)
      rd(3'h4, 16'h0000);
      rd(3'h1, 16'h0800);
      rd(3'h3, 16'h0000);
   endtask : t_avg
   task automatic t_access;
      wr(3'h4, 16'hFFFF);
      rd(3'h4, 16'h0000);
      rd(3'h6, 16'h0000);
   endtask : t_access
   task automatic print_verdict;
      if (err_total == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict
   // watchdog
   initial begin
      #50000;
      err_total++;
      print_verdict();
   end
   initial begin
      {SYS_CLK, REG_WR, REG_RD, SHUNT_VALID, SUPPLY_SENSE_VALID} = 5'h00;
      {REG_ADDR, REG_WDATA, SHUNT_CODE, SUPPLY_SENSE_CODE} = 51'h0;
      RST = 1'h1;
      repeat (20) @(negedge SYS_CLK);
      RST = 1'h0;
      t_uncal();
      t_walk();
      t_avg();
      t_access();
      print_verdict();
   end
endmodule : tb_cpe_engine

// [rtl/cpe_div_if.sv]
// handshake between the engine and its serial divider
`timescale 1ns/1ps
interface cpe_div_if #(parameter int DW = 32, parameter int VW = 16);
   logic start;
   logic [DW-1:0] dividend;
   logic [VW-1:0] divisor;
   logic busy;
   logic done;
   logic [DW-1:0] quotient;
   modport master (output start, output dividend, output divisor,
                   input busy, input done, input quotient);
   modport slave (input start, input dividend, input divisor,
                  output busy, output done, output quotient);
endinterface : cpe_div_if

// [rtl/cpe_divider.sv]
// unsigned restoring divider, one quotient bit per clock
`timescale 1ns/1ps
module cpe_divider #(
   parameter int DW = 32,
   parameter int VW = 16
) (
   input wire logic SYS_CLK,
   input wire logic RST,
   cpe_div_if.slave div
);
   logic [VW:0] rem_r;
   logic [DW-1:0] quo_r;
   logic [$clog2(DW+1)-1:0] cnt_r;
   logic busy_r;
   logic done_r;
   logic [VW:0] trial;
   logic [VW:0] rem_nxt;
   logic bit_nxt;

   // shift in next dividend bit and try a subtraction
   always_comb begin
      trial = {rem_r[VW-1:0], quo_r[DW-1]};
      bit_nxt = (trial >= {1'b0, div.divisor});
      rem_nxt = bit_nxt ? trial - {1'b0, div.divisor} : trial;
   end

   // iteration state; quotient truncates toward zero
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         rem_r <= '0;
         quo_r <= '0;
         cnt_r <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (div.start && !busy_r) begin
            rem_r <= '0;
            quo_r <= div.dividend;
            cnt_r <= ($clog2(DW+1))'(DW);
            busy_r <= 1'b1;
         end else if (busy_r) begin
            rem_r <= rem_nxt;
            quo_r <= {quo_r[DW-2:0], bit_nxt};
            cnt_r <= cnt_r - 1'b1;
            if (cnt_r == 1) begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end
         end
      end
   end

   assign div.busy = busy_r;
   assign div.done = done_r;
   assign div.quotient = quo_r;
endmodule : cpe_divider

// [rtl/cpe_engine.sv]
// current and power arithmetic engine with its result registers
`timescale 1ns/1ps
`include "cpe_regs.svh"
module cpe_engine #(
   parameter int AVG_LOG2_MAX = 10,
   parameter int ACC_W = 27
) (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic [2:0] REG_ADDR,
   input wire logic [15:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [15:0] REG_RDATA,
   input wire logic [15:0] SHUNT_CODE,
   input wire logic SHUNT_VALID,
   input wire logic [15:0] SUPPLY_SENSE_CODE,
   input wire logic SUPPLY_SENSE_VALID,
   output logic [2:0] SHUNT_TIME_SEL,
   output logic [2:0] SUPPLY_TIME_SEL,
   output logic [2:0] AVG_COUNT_SEL,
   output logic RESULT_READY
);
   // accumulators must hold 2^AVG_LOG2_MAX signed 16-bit samples
   if (ACC_W < 17 + AVG_LOG2_MAX) begin : g_chk
      $error("cpe_engine: ACC_W too small for averaging depth");
   end

   localparam int PW = 40;

   cpe_pkg::cpe_word_t setup_r;
   cpe_pkg::cpe_word_t scale_r;
   cpe_pkg::cpe_word_t shunt_out_r;
   cpe_pkg::cpe_word_t bus_out_r;
   cpe_pkg::cpe_word_t power_out_r;
   cpe_pkg::cpe_word_t current_out_r;
   cpe_pkg::cpe_word_t rdata_r;
   logic signed [15:0] cur_now_r;
   logic signed [ACC_W-1:0] acc_shunt_r;
   logic signed [ACC_W-1:0] acc_cur_r;
   logic signed [ACC_W-1:0] acc_bus_r;
   logic signed [ACC_W-1:0] acc_pwr_r;
   logic [10:0] cnt_r;
   logic [10:0] cnt_nxt;
   logic ready_r;
   logic avg_end;
   logic restart;
   logic cal_zero;
   logic [3:0] avg_sh;
   logic signed [15:0] cur_calc;
   logic signed [PW-1:0] prod;
   logic [15:0] bus_code;
   logic [15:0] cur_mag;
   logic [15:0] pwr_val;

   cpe_div_if #(.DW(32), .VW(16)) div ();

   cpe_divider #(.DW(32), .VW(16)) u_div (
      .SYS_CLK(SYS_CLK),
      .RST(RST),
      .div(div.slave)
   );

   // averaging code to log2 of the sample count
   function automatic logic [3:0] avg_log2(input logic [2:0] code);
      case (code)
         3'h0: avg_log2 = 4'h0;
         3'h1: avg_log2 = 4'h2;
         3'h2: avg_log2 = 4'h4;
         3'h3: avg_log2 = 4'h6;
         3'h4: avg_log2 = 4'h7;
         3'h5: avg_log2 = 4'h8;
         3'h6: avg_log2 = 4'h9;
         default: avg_log2 = 4'hA;
      endcase
   endfunction : avg_log2

   // signed divide by a power of two, truncating toward zero
   function automatic logic signed [PW-1:0] shr_trunc(
      input logic signed [PW-1:0] v, input logic [5:0] sh);
      logic signed [PW-1:0] mag;
      mag = v[PW-1] ? -v : v;
      mag = mag >>> sh;
      shr_trunc = v[PW-1] ? -mag : mag;
   endfunction : shr_trunc

   // shunt code times calibration, divided by 2048
   always_comb begin
      prod = PW'($signed(SHUNT_CODE) * $signed({1'b0, scale_r}));
      cur_calc = 16'(shr_trunc(prod, `CPE_CURRENT_SHIFT));
   end

   assign cal_zero = (scale_r == `CPE_SCALE_RESET);
   assign avg_sh = avg_log2(setup_r[`CPE_AVG_MSB:`CPE_AVG_LSB]);
   assign bus_code = {1'b0, SUPPLY_SENSE_CODE[`CPE_BUS_MSB-1:0]};
   assign cur_mag = cur_now_r[15] ? 16'(-cur_now_r) : 16'(cur_now_r);
   assign restart = REG_WR && (REG_ADDR == `CPE_ADDR_SETUP);
   assign cnt_nxt = cnt_r + 11'h001;
   assign avg_end = div.done && (cnt_nxt == (11'h001 << avg_sh));

   // power magnitude saturates, step is 25 current steps
   assign pwr_val = cal_zero ? 16'h0000 :
      (div.quotient[31:16] != 16'h0000) ? `CPE_POWER_SAT :
      div.quotient[15:0];

   // power division request after each bus sample that finds the divider idle
   assign div.start = SUPPLY_SENSE_VALID && !div.busy;
   assign div.dividend = 32'(cur_mag * bus_code);
   assign div.divisor = `CPE_POWER_DIVISOR;

   // setup and calibration registers, software writable
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         setup_r <= `CPE_SETUP_RESET;
         scale_r <= `CPE_SCALE_RESET;
      end else if (REG_WR) begin
         if (REG_ADDR == `CPE_ADDR_SETUP)
            setup_r <= REG_WDATA;
         if (REG_ADDR == `CPE_ADDR_SCALE)
            scale_r <= REG_WDATA;
      end
   end

   // most recent current, used by the next power step
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         cur_now_r <= '0;
      end else if (SHUNT_VALID) begin
         cur_now_r <= cal_zero ? 16'sh0000 : cur_calc;
      end
   end

   // shunt and current sums over the averaging window
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         acc_shunt_r <= '0;
         acc_cur_r <= '0;
      end else if (restart || avg_end) begin
         acc_shunt_r <= SHUNT_VALID ? ACC_W'($signed(SHUNT_CODE)) : '0;
         acc_cur_r <= (SHUNT_VALID && !cal_zero) ?
            ACC_W'(cur_calc) : '0;
      end else if (SHUNT_VALID) begin
         acc_shunt_r <= acc_shunt_r + ACC_W'($signed(SHUNT_CODE));
         acc_cur_r <= acc_cur_r +
            (cal_zero ? ACC_W'(0) : ACC_W'(cur_calc));
      end
   end

   // bus voltage sum, sampled with the power request
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         acc_bus_r <= '0;
      end else if (restart || avg_end) begin
         acc_bus_r <= div.start ? ACC_W'({1'b0, bus_code}) : '0;
      end else if (div.start) begin
         acc_bus_r <= acc_bus_r + ACC_W'({1'b0, bus_code});
      end
   end

   // power sum and sample count; window closes on last power
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         acc_pwr_r <= '0;
         cnt_r <= '0;
      end else if (restart || avg_end) begin
         acc_pwr_r <= '0;
         cnt_r <= '0;
      end else if (div.done) begin
         acc_pwr_r <= acc_pwr_r + ACC_W'({1'b0, pwr_val});
         cnt_r <= cnt_nxt;
      end
   end

   // load averages into output registers at window end
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         shunt_out_r <= `CPE_RESULT_RESET;
         bus_out_r <= `CPE_RESULT_RESET;
         current_out_r <= `CPE_RESULT_RESET;
         power_out_r <= `CPE_RESULT_RESET;
         ready_r <= 1'b0;
      end else begin
         ready_r <= avg_end && !restart;
         if (avg_end && !restart) begin
            shunt_out_r <= 16'(shr_trunc(PW'(acc_shunt_r),
               6'(avg_sh)));
            bus_out_r <= 16'(shr_trunc(PW'(acc_bus_r),
               6'(avg_sh))) & 16'h7FFF;
            current_out_r <= cal_zero ? 16'h0000 :
               16'(shr_trunc(PW'(acc_cur_r), 6'(avg_sh)));
            power_out_r <= cal_zero ? 16'h0000 :
               16'(shr_trunc(PW'(acc_pwr_r + ACC_W'({1'b0, pwr_val})),
               6'(avg_sh)));
         end
      end
   end

   // register read port, data one clock after the strobe
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         rdata_r <= '0;
      end else if (REG_RD) begin
         case (REG_ADDR)
            `CPE_ADDR_SETUP: rdata_r <= setup_r;
            `CPE_ADDR_SHUNT: rdata_r <= shunt_out_r;
            `CPE_ADDR_BUS: rdata_r <= bus_out_r;
            `CPE_ADDR_POWER: rdata_r <= power_out_r;
            `CPE_ADDR_CURRENT: rdata_r <= current_out_r;
            `CPE_ADDR_SCALE: rdata_r <= scale_r;
            default: rdata_r <= '0; // unmapped
         endcase
      end
   end

   assign REG_RDATA = rdata_r;
   assign SHUNT_TIME_SEL = setup_r[`CPE_SHCT_MSB:`CPE_SHCT_LSB];
   assign SUPPLY_TIME_SEL = setup_r[`CPE_BUSCT_MSB:`CPE_BUSCT_LSB];
   assign AVG_COUNT_SEL = setup_r[`CPE_AVG_MSB:`CPE_AVG_LSB];
   assign RESULT_READY = ready_r;
endmodule : cpe_engine

// [rtl/cpe_pkg.sv]
// shared types of the current and power engine
package cpe_pkg;
   typedef logic [2:0] cpe_addr_t;
   typedef logic [15:0] cpe_word_t;
endpackage : cpe_pkg

// [rtl/cpe_regs.svh]
// register map, field positions, reset values and scaling constants
// What this block does
// - current is shunt times calibration over 2048
// - power is current times bus over 20000
// - power step fixed at 25 current steps
// - current and power zero until calibrated
// - results refresh at the end of each averaging window unless setup is written in that cycle
// - bus voltage weight fixed 1.25 mV per step
// - bus voltage register top bit always zero
// - shunt voltage weight 2.5 uV per step
// - conversion times and averaging set independently
// - current per shunt sample, power per bus sample that finds the divider idle
// - average internally, load only final averages
`ifndef CPE_REGS_SVH
`define CPE_REGS_SVH

`define CPE_ADDR_SETUP 3'h0
`define CPE_ADDR_SHUNT 3'h1
`define CPE_ADDR_BUS 3'h2
`define CPE_ADDR_POWER 3'h3
`define CPE_ADDR_CURRENT 3'h4
`define CPE_ADDR_SCALE 3'h5

`define CPE_SETUP_RESET 16'h4127
`define CPE_SCALE_RESET 16'h0000
`define CPE_RESULT_RESET 16'h0000

// measurement_setup fields
`define CPE_AVG_MSB 11
`define CPE_AVG_LSB 9
`define CPE_BUSCT_MSB 8
`define CPE_BUSCT_LSB 6
`define CPE_SHCT_MSB 5
`define CPE_SHCT_LSB 3

// current scaling shift (divide by 2048) and power divisor
`define CPE_CURRENT_SHIFT 6'd11
`define CPE_POWER_DIVISOR 16'h4E20
`define CPE_BUS_MSB 15
`define CPE_POWER_SAT 16'hFFFF

`endif
